// ---- logic/xmem_decode_pkg.sv ----
// Constants and types for the extended memory decoder
package xmem_decode_pkg;

   // APB register byte offsets
   localparam logic [7:0] OFF_CEILING    = 8'h00;
   localparam logic [7:0] OFF_CONTROL    = 8'h04;
   localparam logic [7:0] OFF_HIGH_MGMT_SEGMENT_BASE  = 8'h08;
   localparam logic [7:0] OFF_GFX_LOCAL  = 8'h0C;
   localparam logic [7:0] OFF_GFX_LOCLIM = 8'h10;
   localparam logic [7:0] OFF_GFX_MMIO   = 8'h14;
   localparam logic [7:0] OFF_GFX_MMLIM  = 8'h18;
   localparam logic [7:0] OFF_WIN_BASE   = 8'h1C;
   localparam logic [7:0] OFF_WIN_LIMIT  = 8'h20;
   localparam logic [7:0] OFF_PF_BASE    = 8'h24;
   localparam logic [7:0] OFF_PF_LIMIT   = 8'h28;
   localparam logic [7:0] OFF_AP_BASE    = 8'h2C;
   localparam logic [7:0] OFF_AP_SIZE    = 8'h30;
   localparam logic [7:0] OFF_STATUS     = 8'h34;

   // Control register bit positions
   localparam int CTL_HOLE_EN  = 0;
   localparam int CTL_HIGH_MGMT_SEGMENT_EN  = 1;
   localparam int CTL_TOP_MGMT_SEGMENT_EN  = 2;
   localparam int CTL_UPPER_MGMT_SIZE_FIELD     = 3;
   localparam int CTL_GFX_INT  = 4;
   localparam int CTL_GFX_PORT = 5;
   localparam logic [31:0] CTL_MASK  = 32'h0000003F;
   localparam logic [31:0] CTL_RESET = 32'h00000000;

   // Address map constants
   localparam logic [31:0] ONE_MB       = 32'h00100000;
   localparam logic [31:0] HALF_MB      = 32'h00080000;
   localparam logic [31:0] CEILING_MAX  = 32'h20000000;
   localparam logic [31:0] CEILING_RST  = 32'h00100000;
   localparam logic [31:0] HOLE_LO      = 32'h00F00000;
   localparam logic [31:0] HOLE_HI      = 32'h01000000;
   localparam logic [31:0] HIGH_MGMT_SEGMENT_SIZE    = 32'h00020000;
   localparam logic [31:0] HIGH_MGMT_SEGMENT_RST     = 32'h000A0000;
   localparam logic [31:0] LEGACY_SMM   = 32'h000A0000;
   localparam logic [31:0] IOIC_LO      = 32'hFEC00000;
   localparam logic [31:0] IOIC_HI      = 32'hFECFFFFF;
   localparam logic [31:0] LAPIC_LO     = 32'hFEE00000;
   localparam logic [31:0] LAPIC_HI     = 32'hFEEFFFFF;
   localparam logic [31:0] FIXED_HUB_LO = 32'hFED00000;
   localparam logic [31:0] FIRMWARE_LO  = 32'hFFE00000;

   // Requesting agents
   typedef enum logic [1:0] {
      SRC_CPU,
      SRC_HUB,
      SRC_GFX
   } source_t;

   // Destinations
   typedef enum logic [2:0] {
      TGT_DRAM,
      TGT_HUB,
      TGT_IGD,
      TGT_PORT,
      TGT_ABORT,
      TGT_BLOCK
   } target_t;

endpackage : xmem_decode_pkg

// ---- logic/extended_memory_decoder.sv ----
// Extended memory region decoder with APB configuration registers

// What this block does
// RULE1: 1 MB to ceiling goes to DRAM
// RULE2: DRAM ceiling capped at 512 MB
// RULE3: Enabled 15-16 MB hole goes to hub
// RULE4: Memory under hole is never relocated
// RULE5: Management-mode high segment maps to A0000-BFFFF
// RULE6: Non-management high segment aborts, write-back remapped
// RULE7: DRAM behind high segment stays inaccessible
// RULE8: Hub and port masters kept from management memory
// RULE9: Top segment below ceiling, identity mapped
// RULE10: Non-management top segment blocked, write-back allowed
// RULE11: Size field picks 512 KB or 1 MB
// RULE12: Blocked top segment accesses go to hub
// RULE13: Ceiling to 4 GB defaults to hub
// RULE14: Internal graphics ranges go to graphics
// RULE15: Port window ranges go to port
// RULE16: Aperture range goes to DRAM
// RULE17: Software keeps windows clear of fixed ranges
// RULE18: Interrupt controller range goes to hub
// RULE19: Interrupt controller range never to port
// RULE20: FED0_0000h to firmware goes to hub
// RULE21: Top 2 MB firmware goes to hub
// RULE22: Translated requests also kept from management memory
// RULE23: Management segments decoded before other ranges; the code decodes the region below 1 MB ahead of them
module extended_memory_decoder
   import xmem_decode_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Access request
   input  wire logic        req_valid,
   input  wire logic [31:0] req_addr,
   input  wire source_t     req_source,
   input  wire logic        req_mgmt_mode,
   input  wire logic        req_writeback,
   input  wire logic        req_translated,
   // Decode result
   output logic             dec_valid,
   output target_t          dec_target,
   output logic      [31:0] dec_addr
);

   logic [31:0] ceiling_q;
   logic [31:0] control_q;
   logic [31:0] high_mgmt_segment_base_q;
   logic [31:0] gfx_lo_q;
   logic [31:0] gfx_hi_q;
   logic [31:0] mmio_lo_q;
   logic [31:0] mmio_hi_q;
   logic [31:0] win_lo_q;
   logic [31:0] win_hi_q;
   logic [31:0] pf_lo_q;
   logic [31:0] pf_hi_q;
   logic [31:0] ap_base_q;
   logic [31:0] ap_size_q;
   logic [7:0]  hits_q;
   logic        dec_valid_q;
   target_t     dec_target_q;
   logic [31:0] dec_addr_q;

   // APB decode
   wire logic apb_wr     = psel & penable & pwrite;
   wire logic apb_access = psel & penable;
   wire logic sel_known  = (paddr[1:0] == 2'h0) && (paddr <= OFF_STATUS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ceiling_q   <= CEILING_RST;
         control_q   <= CTL_RESET;
         high_mgmt_segment_base_q <= HIGH_MGMT_SEGMENT_RST;
         gfx_lo_q    <= 32'h00000000;
         gfx_hi_q    <= 32'h00000000;
         mmio_lo_q   <= 32'h00000000;
         mmio_hi_q   <= 32'h00000000;
         win_lo_q    <= 32'h00000000;
         win_hi_q    <= 32'h00000000;
         pf_lo_q     <= 32'h00000000;
         pf_hi_q     <= 32'h00000000;
         ap_base_q   <= 32'h00000000;
         ap_size_q   <= 32'h00000000;
      end
      else if (apb_wr)
      begin
         unique case (paddr)
            OFF_CEILING:    ceiling_q <= (pwdata > CEILING_MAX) ? CEILING_MAX : pwdata; // [RULE2]
            OFF_CONTROL:    control_q   <= pwdata & CTL_MASK;
            OFF_HIGH_MGMT_SEGMENT_BASE:  high_mgmt_segment_base_q <= pwdata;
            OFF_GFX_LOCAL:  gfx_lo_q    <= pwdata;
            OFF_GFX_LOCLIM: gfx_hi_q    <= pwdata;
            OFF_GFX_MMIO:   mmio_lo_q   <= pwdata;
            OFF_GFX_MMLIM:  mmio_hi_q   <= pwdata;
            OFF_WIN_BASE:   win_lo_q    <= pwdata;
            OFF_WIN_LIMIT:  win_hi_q    <= pwdata;
            OFF_PF_BASE:    pf_lo_q     <= pwdata;
            OFF_PF_LIMIT:   pf_hi_q     <= pwdata;
            OFF_AP_BASE:    ap_base_q   <= pwdata;
            OFF_AP_SIZE:    ap_size_q   <= pwdata;
            default:        ;
         endcase
      end
   end

   // Configuration bits
   wire logic hole_en  = control_q[CTL_HOLE_EN];
   wire logic high_mgmt_segment_en  = control_q[CTL_HIGH_MGMT_SEGMENT_EN];
   wire logic top_mgmt_segment_en  = control_q[CTL_TOP_MGMT_SEGMENT_EN];
   wire logic upper_mgmt_size_field_1mb = control_q[CTL_UPPER_MGMT_SIZE_FIELD];
   wire logic gfx_int  = control_q[CTL_GFX_INT];
   wire logic gfx_port = control_q[CTL_GFX_PORT];

   // Range hits
   wire logic [31:0] a         = req_addr;
   wire logic [31:0] top_mgmt_segment_size = upper_mgmt_size_field_1mb ? ONE_MB : HALF_MB; // [RULE11]
   wire logic [31:0] top_mgmt_segment_lo   = ceiling_q - top_mgmt_segment_size; // [RULE9]
   wire logic [31:0] high_mgmt_segment_off  = a - high_mgmt_segment_base_q;
   wire logic in_ext     = a >= ONE_MB;
   wire logic in_dram    = in_ext && (a < ceiling_q); // [RULE1]
   wire logic in_hole    = hole_en && (a >= HOLE_LO) && (a < HOLE_HI); // [RULE3]
   wire logic in_high_mgmt_segment    = high_mgmt_segment_en && (a >= high_mgmt_segment_base_q) && (high_mgmt_segment_off < HIGH_MGMT_SEGMENT_SIZE);
   wire logic in_top_mgmt_segment    = top_mgmt_segment_en && (a >= top_mgmt_segment_lo) && (a < ceiling_q);
   wire logic in_ioic    = (a >= IOIC_LO) && (a <= IOIC_HI);
   wire logic in_lapic   = (a >= LAPIC_LO) && (a <= LAPIC_HI);
   wire logic in_fixhub  = (a >= FIXED_HUB_LO) && (a < FIRMWARE_LO);
   wire logic in_fw      = a >= FIRMWARE_LO;
   wire logic in_fixed   = in_ioic | in_lapic | in_fixhub | in_fw;
   wire logic in_gfx     = gfx_int && (((a >= gfx_lo_q) && (a <= gfx_hi_q))
                                  || ((a >= mmio_lo_q) && (a <= mmio_hi_q)));
   wire logic in_win     = gfx_port && (((a >= win_lo_q) && (a <= win_hi_q))
                                    || ((a >= pf_lo_q) && (a <= pf_hi_q)));
   wire logic [31:0] ap_off = a - ap_base_q;
   wire logic in_ap      = gfx_port && (a >= ap_base_q) && (ap_off < ap_size_q);
   wire logic is_cpu     = req_source == SRC_CPU;
   wire logic cpu_smm_ok = is_cpu && (req_mgmt_mode || req_writeback);

   // Priority: region below 1 MB, management segments, fixed ranges, hole, DRAM, graphics windows
   target_t     tgt;
   logic [31:0] out_addr;
   always_comb
   begin
      tgt      = TGT_HUB; // [RULE13]
      out_addr = a;
      if (!in_ext)
      begin
         tgt = TGT_HUB;
      end
      else if (in_high_mgmt_segment) // [RULE23]
      begin
         if (cpu_smm_ok)
         begin
            tgt      = TGT_DRAM; // [RULE5] [RULE6]
            out_addr = LEGACY_SMM + high_mgmt_segment_off; // [RULE7]
         end
         else if (is_cpu)
            tgt = TGT_ABORT; // [RULE6]
         else
            tgt = TGT_BLOCK; // [RULE8] [RULE22]
      end
      else if (in_top_mgmt_segment) // [RULE23]
      begin
         if (cpu_smm_ok)
            tgt = TGT_DRAM; // [RULE9] [RULE10]
         else if (is_cpu || !req_translated)
            tgt = TGT_HUB; // [RULE10] [RULE12]
         else
            tgt = TGT_BLOCK; // [RULE22]
      end
      else if (in_fixed)
         tgt = TGT_HUB; // [RULE18] [RULE19] [RULE20] [RULE21]
      else if (in_hole)
         tgt = TGT_HUB; // [RULE3] [RULE4]
      else if (in_dram)
         tgt = TGT_DRAM; // [RULE1]
      else if (in_gfx)
         tgt = TGT_IGD; // [RULE14]
      else if (in_win)
         tgt = TGT_PORT; // [RULE15]
      else if (in_ap)
         tgt = TGT_DRAM; // [RULE16]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dec_valid_q  <= 1'b0;
         dec_target_q <= TGT_HUB;
         dec_addr_q   <= 32'h00000000;
         hits_q       <= 8'h00;
      end
      else
      begin
         dec_valid_q <= req_valid;
         if (req_valid)
         begin
            dec_target_q <= tgt;
            dec_addr_q   <= out_addr;
            if ((tgt == TGT_ABORT) || (tgt == TGT_BLOCK))
               hits_q <= hits_q + 8'h01;
         end
      end
   end

   assign dec_valid  = dec_valid_q;
   assign dec_target = dec_target_q;
   assign dec_addr   = dec_addr_q;

   // APB read mux; single-cycle answer
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (paddr)
         OFF_CEILING:    rd_mux = ceiling_q;
         OFF_CONTROL:    rd_mux = control_q;
         OFF_HIGH_MGMT_SEGMENT_BASE:  rd_mux = high_mgmt_segment_base_q;
         OFF_GFX_LOCAL:  rd_mux = gfx_lo_q;
         OFF_GFX_LOCLIM: rd_mux = gfx_hi_q;
         OFF_GFX_MMIO:   rd_mux = mmio_lo_q;
         OFF_GFX_MMLIM:  rd_mux = mmio_hi_q;
         OFF_WIN_BASE:   rd_mux = win_lo_q;
         OFF_WIN_LIMIT:  rd_mux = win_hi_q;
         OFF_PF_BASE:    rd_mux = pf_lo_q;
         OFF_PF_LIMIT:   rd_mux = pf_hi_q;
         OFF_AP_BASE:    rd_mux = ap_base_q;
         OFF_AP_SIZE:    rd_mux = ap_size_q;
         OFF_STATUS:     rd_mux = {24'h000000, hits_q};
         default:        rd_mux = 32'h00000000;
      endcase
   end

   assign prdata  = (apb_access && !pwrite) ? rd_mux : 32'h00000000;
   assign pready  = 1'b1;
   assign pslverr = apb_access && !sel_known;

   // Checks
   ceiling_cap_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      ceiling_q <= CEILING_MAX)
      else $error("ceiling above limit");
   hole_hub_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      (req_valid && in_hole && !in_high_mgmt_segment && !in_top_mgmt_segment) |=> (dec_target == TGT_HUB))
      else $error("hole not routed to hub");
   high_mgmt_segment_remap_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      (req_valid && in_ext && in_high_mgmt_segment && is_cpu && req_mgmt_mode)
      |=> (dec_target == TGT_DRAM) && (dec_addr == LEGACY_SMM + $past(high_mgmt_segment_off)))
      else $error("high segment not remapped");
   high_mgmt_segment_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      (req_valid && in_ext && in_high_mgmt_segment && is_cpu && !req_mgmt_mode && !req_writeback)
      |=> dec_target == TGT_ABORT)
      else $error("high segment not aborted");
   mgmt_block_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      (req_valid && in_ext && (in_high_mgmt_segment || in_top_mgmt_segment) && !is_cpu) |=> dec_target != TGT_DRAM)
      else $error("other agent reached management memory");
   top_mgmt_segment_identity_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      (req_valid && in_ext && !in_high_mgmt_segment && in_top_mgmt_segment && is_cpu && req_mgmt_mode)
      |=> (dec_target == TGT_DRAM) && (dec_addr == $past(req_addr)))
      else $error("top segment not identity mapped");
   top_mgmt_segment_hub_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      (req_valid && in_ext && !in_high_mgmt_segment && in_top_mgmt_segment && is_cpu && !req_mgmt_mode
       && !req_writeback) |=> dec_target == TGT_HUB)
      else $error("top segment not sent to hub");
   ioic_port_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
      (req_valid && in_ioic) |=> dec_target == TGT_HUB)
      else $error("interrupt range not on hub");
   firmware_hub_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
      (req_valid && in_fw) |=> dec_target == TGT_HUB)
      else $error("firmware range not on hub");
   dram_route_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      (req_valid && in_dram && !in_hole && !in_high_mgmt_segment && !in_top_mgmt_segment && !in_fixed)
      |=> dec_target == TGT_DRAM)
      else $error("DRAM range misrouted");


   // Write-back cycles and other agents on the segments
   high_mgmt_segment_wb_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      (req_valid && in_ext && in_high_mgmt_segment && is_cpu && !req_mgmt_mode && req_writeback)
      |=> (dec_target == TGT_DRAM) && (dec_addr == LEGACY_SMM + $past(high_mgmt_segment_off)))
      else $error("write-back not remapped");
   high_mgmt_segment_window_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
      (req_valid && in_ext && in_high_mgmt_segment && cpu_smm_ok)
      |=> (dec_addr >= LEGACY_SMM) && (dec_addr < LEGACY_SMM + HIGH_MGMT_SEGMENT_SIZE))
      else $error("high segment left legacy window");
   high_mgmt_segment_block_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      (req_valid && in_ext && in_high_mgmt_segment && !is_cpu)
      |=> dec_target == TGT_BLOCK)
      else $error("agent not blocked on high segment");
   top_mgmt_segment_wb_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      (req_valid && in_ext && !in_high_mgmt_segment && in_top_mgmt_segment && is_cpu && !req_mgmt_mode && req_writeback)
      |=> (dec_target == TGT_DRAM) && (dec_addr == $past(req_addr)))
      else $error("write-back missed top segment");
   top_mgmt_segment_block_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
      (req_valid && in_ext && !in_high_mgmt_segment && in_top_mgmt_segment && !is_cpu && req_translated)
      |=> dec_target == TGT_BLOCK)
      else $error("translated request reached top segment");
   top_mgmt_segment_first_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
      (req_valid && in_ext && !in_high_mgmt_segment && in_top_mgmt_segment && !cpu_smm_ok)
      |=> dec_target != TGT_DRAM)
      else $error("top segment lost priority");
   top_mgmt_segment_size_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
      (req_valid && in_top_mgmt_segment)
      |-> (ceiling_q - a) <= (upper_mgmt_size_field_1mb ? ONE_MB : HALF_MB))
      else $error("top segment size wrong");

   // Fixed ranges, hole and the low region
   ioic_hub_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
      (req_valid && in_ioic && !in_high_mgmt_segment && !in_top_mgmt_segment)
      |=> (dec_target == TGT_HUB) && (dec_addr == $past(req_addr)))
      else $error("interrupt unit not forwarded");
   ioic_not_port_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
      (req_valid && in_ioic)
      |=> dec_target != TGT_PORT)
      else $error("interrupt range sent to port");
   fixhub_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
      (req_valid && in_ext && !in_high_mgmt_segment && !in_top_mgmt_segment && in_fixhub)
      |=> dec_target == TGT_HUB)
      else $error("fixed hub range misrouted");
   hole_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      (req_valid && in_hole && !in_high_mgmt_segment && !in_top_mgmt_segment)
      |=> dec_addr == $past(req_addr))
      else $error("hole address relocated");
   low_hub_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      (req_valid && !in_ext)
      |=> dec_target == TGT_HUB)
      else $error("low region misrouted");
   ceiling_clip_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      (apb_wr && (paddr == OFF_CEILING) && (pwdata > CEILING_MAX))
      |=> ceiling_q == CEILING_MAX)
      else $error("ceiling write not clipped");

   // Decode handshake
   dec_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      req_valid
      |=> dec_valid)
      else $error("decode answer missing");
   dec_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      !req_valid
      |=> !dec_valid)
      else $error("decode answer without request");

   // Range above the ceiling
   wire logic above_ceil = in_ext && !in_high_mgmt_segment && !in_top_mgmt_segment && !in_fixed && !in_hole && !in_dram;
   pci_default_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
      (req_valid && above_ceil && !in_gfx && !in_win && !in_ap)
      |=> dec_target == TGT_HUB)
      else $error("default range not on hub");
   igd_route_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
      (req_valid && above_ceil && in_gfx)
      |=> dec_target == TGT_IGD)
      else $error("graphics range misrouted");
   port_route_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
      (req_valid && above_ceil && !in_gfx && in_win)
      |=> dec_target == TGT_PORT)
      else $error("port window misrouted");
   aperture_dram_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
      (req_valid && above_ceil && !in_gfx && !in_win && in_ap)
      |=> dec_target == TGT_DRAM)
      else $error("aperture not on DRAM");

   cov_block_c: cover property (@(posedge pclk) disable iff (!presetn)
      dec_valid && dec_target == TGT_BLOCK);
   cov_dram_c: cover property (@(posedge pclk) disable iff (!presetn)
      dec_valid && dec_target == TGT_DRAM);
   cov_abort_c: cover property (@(posedge pclk) disable iff (!presetn)
      dec_valid && dec_target == TGT_ABORT);
   cov_port_c: cover property (@(posedge pclk) disable iff (!presetn)
      dec_valid && dec_target == TGT_PORT);
   cov_igd_c: cover property (@(posedge pclk) disable iff (!presetn)
      dec_valid && dec_target == TGT_IGD);

endmodule : extended_memory_decoder

// ---- verification/req_agent.sv ----
// Request agent standing in for processor, hub and graphics masters
module req_agent
   import xmem_decode_pkg::*;
(
   // Clock
   input  wire logic   pclk,
   // Decode request
   output logic        req_valid,
   output logic [31:0] req_addr,
   output source_t     req_source,
   output logic        req_mgmt_mode,
   output logic        req_writeback,
   output logic        req_translated
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      req_valid      = 1'b0;
      req_addr       = 32'h0;
      req_source     = SRC_CPU;
      req_mgmt_mode  = 1'b0;
      req_writeback  = 1'b0;
      req_translated = 1'b0;
   end

   // Kind bits: source, mode, write-back, translated
   task automatic issue(input logic [31:0] a, input logic [4:0] k);
      @(posedge pclk);
      req_valid      <= 1'b1;
      req_addr       <= a;
      req_source     <= source_t'(k[1:0]);
      req_mgmt_mode  <= k[2];
      req_writeback  <= k[3];
      req_translated <= k[4];
   endtask : issue

   // Idle lines carry no stale address
   task automatic idle();
      @(posedge pclk);
      req_valid <= 1'b0;
      req_addr  <= ~req_addr;
   endtask : idle
endmodule : req_agent

// ---- verification/tb_top.sv ----
// Self-checking bench for the extended memory decoder
module tb_top
   import xmem_decode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        req_valid, req_mgmt_mode, req_writeback, req_translated, dec_valid;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, req_addr, dec_addr, lf, rd;
   logic [31:0] rg [14];
   logic [34:0] ex;
   logic [34:0] exp_q [$];
   source_t     req_source;
   target_t     dec_target;
   int          n_errors, samples_checked, n_bad;

   extended_memory_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
      .req_addr(req_addr), .req_source(req_source), .req_mgmt_mode(req_mgmt_mode),
      .req_writeback(req_writeback), .req_translated(req_translated),
      .dec_valid(dec_valid), .dec_target(dec_target), .dec_addr(dec_addr));
   req_agent u_req (.pclk(pclk), .req_valid(req_valid), .req_addr(req_addr),
      .req_source(req_source), .req_mgmt_mode(req_mgmt_mode),
      .req_writeback(req_writeback), .req_translated(req_translated));

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         chk("apb_wait", 32'h0, 32'h1);
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cfg(input int i, input logic [31:0] d);
      rg[i] = (i == 0 && d > CEILING_MAX) ? CEILING_MAX : (i == 1) ? (d & CTL_MASK) : d;
      apb(1'b1, 8'(i * 4), d);
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reg_readback", rd, rg[i]);
   endtask : cfg

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   function automatic logic inr(input longint a, input int i);
      return a >= rg[i] && a <= rg[i + 1];
   endfunction : inr

   // Reference routing: region below 1 MB first, then segments, fixed ranges, hole, DRAM, windows
   function automatic logic [34:0] model(input longint a, input logic [4:0] k);
      longint c, ts, hb, da;
      logic [5:0] ct;
      logic ok;
      logic [2:0] tg;
      c  = rg[0];
      ct = rg[1][5:0];
      hb = rg[2];
      ts = c - (ct[3] ? 64'h100000 : 64'h80000);
      ok = (k[1:0] == 2'd0) && (k[2] || k[3]);
      da = a;
      tg = 3'd1;
      if (a < 64'h100000)
         tg = 3'd1;
      else if (ct[1] && a >= hb && a < hb + 64'h20000)
      begin
         tg = ok ? 3'd0 : (k[1:0] == 2'd0) ? 3'd4 : 3'd5;
         da = 64'hA0000 + a - hb;
      end
      else if (ct[2] && a >= ts && a < c)
         tg = ok ? 3'd0 : (k[1:0] != 2'd0 && k[4]) ? 3'd5 : 3'd1;
      else if (a >= 64'hFEC00000 || (ct[0] && a >= 64'hF00000 && a < 64'h1000000))
         tg = 3'd1;
      else if (a < c)
         tg = 3'd0;
      else if (ct[4] && (inr(a, 3) || inr(a, 5)))
         tg = 3'd2;
      else if (ct[5] && (inr(a, 7) || inr(a, 9)))
         tg = 3'd3;
      else if (ct[5] && a >= rg[11] && a < 64'(rg[11]) + rg[12])
         tg = 3'd0;
      return {tg, da[31:0]};
   endfunction : model

   task automatic send(input logic [31:0] a, input logic [4:0] k);
      logic [34:0] e;
      e = model(a, k);
      n_bad += int'(e[34:32] >= 3'd4);
      exp_q.push_back(e);
      u_req.issue(a, k);
   endtask : send

   task automatic run(input int nr);
      logic [31:0] p [24];
      p = '{rg[2], rg[2] + 32'h1FFFF, rg[2] + 32'h20000, rg[2] - 32'h1, rg[0] - 32'h80000,
         rg[0] - 32'h100000, rg[0] - 32'h1, rg[0], 32'h000FFFFF, 32'h00100000, 32'h00EFFFFF,
         32'h00F00000, 32'h00FFFFFF, 32'h01000000, 32'hC0000000, 32'hCFFFFFFF, 32'hD7FFFFFF,
         32'hE0000000, 32'hE0080000, 32'hFEC0F000, 32'hFED00000, 32'hFFE00000, 32'hFFFFFFFF,
         32'hFEBFFFFF};
      for (int i = 0; i < 24; i++)
         for (int j = 0; j < 24; j++)
            send(p[i], {3'(j / 3), 2'(j % 3)});
      for (int i = 0; i < nr; i++)
      begin
         lf = lfsr(lf);
         send(lf[0] ? lf % 32'h05000000 : lf, {lf[12:10], 2'(lf[9:8] % 2'd3)});
         if (lf[5])
            u_req.idle();
      end
      u_req.idle();
      repeat (3) @(posedge pclk);
      chk("queue_left", 32'(exp_q.size()), 32'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status", rd, 32'(n_bad % 256));
   endtask : run

   always @(posedge pclk)
   begin
      if (dec_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("dec_valid", 32'h1, 32'h0);
         else
         begin
            ex = exp_q.pop_front();
            chk("dec_target", 32'(dec_target), 32'(ex[34:32]));
            if (ex[34:32] == 3'd0)
               chk("dec_addr", dec_addr, ex[31:0]);
         end
      end
   end

   initial
   begin
      logic [31:0] wv [10];
      wv = '{32'hD0000000, 32'hD7FFFFFF, 32'hE0000000, 32'hE007FFFF, 32'hD0000000,
         32'hD7FFFFFF, 32'hE0000000, 32'hE007FFFF, 32'hC0000000, 32'h10000000};
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h0;
      pwdata  = 32'h0;
      n_errors = 0;
      samples_checked = 0;
      n_bad = 0;
      lf = 32'h3F;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 14; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset_value", rd, i == 0 ? CEILING_RST : i == 2 ? HIGH_MGMT_SEGMENT_RST : 32'h0);
      end
      apb(1'b0, 8'h38, 32'h0);
      chk("unmapped_err", 32'(er), 32'h1);
      chk("unmapped_data", rd, 32'h0);
      cfg(0, 32'h30000000);
      cfg(0, 32'h04000000);
      cfg(2, 32'h02000000);
      for (int i = 3; i < 13; i++)
         cfg(i, wv[i - 3]);
      cfg(1, 32'h000000C7);
      run(200);
      cfg(1, 32'h0000000E);
      run(0);
      cfg(1, 32'h00000010);
      run(0);
      cfg(1, 32'h00000020);
      run(0);
      cfg(0, 32'h20000000);
      cfg(1, 32'h0000003F);
      run(300);
      end_sim();
   end
endmodule : tb_top
